// *** rtl/msr_pkg.sv ***
// Package: offsets, field positions, constants and carriers for the status/identifier bank
package msr_pkg;
  localparam logic [4:0] MSR_REG_STATUS = 5'h01;
  localparam logic [4:0] MSR_REG_ID_HI = 5'h02;
  localparam logic [4:0] MSR_REG_ID_LO = 5'h03;
  localparam logic [4:0] MSR_REG_EXT_STATUS = 5'h0F;
  localparam int MSR_BIT_EXT_STATUS = 8;
  localparam int MSR_BIT_UNIDIR = 7;
  localparam int MSR_BIT_PREAMBLE_SUP = 6;
  localparam int MSR_BIT_NEG_DONE = 5;
  localparam int MSR_BIT_REMOTE_FAULT = 4;
  localparam int MSR_BIT_NEG_ABLE = 3;
  localparam int MSR_BIT_LINK_UP = 2;
  localparam int MSR_BIT_JABBER = 1;
  localparam int MSR_BIT_EXT_CAP = 0;
  localparam logic [15:0] MSR_STATUS_FIXED = 16'h01C8;
  localparam logic [15:0] MSR_ZERO16 = 16'h0000;
  localparam int MSR_ORG_W = 22;
  localparam int MSR_MODEL_W = 6;
  localparam int MSR_REV_W = 4;
  // Link timer: 10 ms at 40 MHz, rounded down
  localparam int MSR_CLK_HZ = 40000000;
  localparam int MSR_LINK_TIMER_US = 10000;
  localparam int MSR_LINK_TIMER_CYC = (MSR_CLK_HZ / 1000000) * MSR_LINK_TIMER_US;

  typedef struct packed {
    logic sync_ok;
    logic neg_enable;
    logic neg_done;
    logic xcvr_reset_done;
    logic remote_fault;
  } msr_link_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } msr_mgmt_req_s;
endpackage : msr_pkg

// *** rtl/msr_link_qual.sv ***
// Link qualifier: sync loss must persist a full link timer before link drops
`timescale 1ns/1ps
module msr_link_qual import msr_pkg::*; #(
  parameter int LINK_TIMER_CYC = MSR_LINK_TIMER_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Link conditions
  input msr_link_s link_in,
  // Qualified link level
  output logic link_ok
);
  logic [31:0] loss_cnt_q;
  logic link_q;
  logic raw_ok;
  logic sync_held;

  assign sync_held = link_in.sync_ok | (link_q & (loss_cnt_q < 32'(LINK_TIMER_CYC)));
  assign raw_ok = sync_held & (~link_in.neg_enable | link_in.neg_done) & link_in.xcvr_reset_done;
  assign link_ok = link_q;

  // Count consecutive cycles of lost sync
  always_ff @(posedge mclk) begin
    if (!rstn || link_in.sync_ok) begin
      loss_cnt_q <= 32'h00000000;
    end else if (loss_cnt_q < 32'(LINK_TIMER_CYC)) begin
      loss_cnt_q <= loss_cnt_q + 32'h00000001;
    end
  end

  // Link level follows qualified conditions
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      link_q <= 1'b0;
    end else begin
      link_q <= raw_ok;
    end
  end

  chk_drop_after_timer: assert property (@(posedge mclk) disable iff (!rstn)
    (link_q && !link_in.sync_ok && loss_cnt_q < 32'(LINK_TIMER_CYC) && link_in.xcvr_reset_done &&
    (!link_in.neg_enable || link_in.neg_done)) |=> link_q) else $error("link dropped before timer");
  chk_drop_at_timer: assert property (@(posedge mclk) disable iff (!rstn)
    (link_q && !link_in.sync_ok && loss_cnt_q == 32'(LINK_TIMER_CYC)) |=> !link_q) else $error("link held past timer");
  chk_link_needs_sync: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(link_q) |-> $past(link_in.sync_ok)) else $error("link rose without sync");
endmodule : msr_link_qual

// *** rtl/msr_id_rom.sv ***
// Identifier constants for the two identifier registers
`timescale 1ns/1ps
module msr_id_rom import msr_pkg::*; #(
  // Arbitrary neutral identity values
  parameter logic [MSR_ORG_W-1:0] ORG_CODE = 22'h000001,
  parameter logic [MSR_MODEL_W-1:0] MODEL = 6'h01,
  parameter logic [MSR_REV_W-1:0] REV = 4'h1
) (
  // Identifier words
  output logic [15:0] id_hi,
  output logic [15:0] id_lo
);
  assign id_hi = ORG_CODE[MSR_ORG_W-1:6];
  assign id_lo = {ORG_CODE[5:0], MODEL, REV};
endmodule : msr_id_rom

// *** rtl/msr_status_regs.sv ***
// Status and identifier register bank with read-side effects
//
// Summary of operation
// - Status bits 15..9 always read 0
// - Bit 8 reads 1, extended status exists
// - Bit 7 reads 1, writes ignored
// - Bit 6 reads 1, preamble suppression
// - Bit 5 shows negotiation complete, reset 0
// - Bit 4 fault flag, clears on read
// - Bit 3 reads 1, negotiation capable
// - Bit 2 latches low, read refreshes it
// - Link up needs sync and reset done, plus negotiation done when negotiation is enabled
// - Sync loss must outlast link timer
// - Bits 1 and 0 always read 0
// - Two constant identifier registers
`timescale 1ns/1ps
module msr_status_regs import msr_pkg::*; #(
  parameter int LINK_TIMER_CYC = MSR_LINK_TIMER_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Management access
  input msr_mgmt_req_s mgmt_req,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rvalid,
  // Link conditions, including negotiation_sync_indication as sync_ok
  input msr_link_s link_in,
  // Qualified link level
  output logic link_up
);
  logic link_ok;
  logic [15:0] id_hi;
  logic [15:0] id_lo;
  logic link_latch_q;
  logic fault_q;
  logic neg_done_q;
  logic [15:0] rdata_q;
  logic rvalid_q;
  logic rd_status;
  logic [15:0] status_word;

  msr_link_qual #(.LINK_TIMER_CYC(LINK_TIMER_CYC)) u_qual (
    .mclk(mclk),
    .rstn(rstn),
    .link_in(link_in),
    .link_ok(link_ok)
  );

  msr_id_rom u_id (
    .id_hi(id_hi),
    .id_lo(id_lo)
  );

  assign rd_status = mgmt_req.rd && (mgmt_req.addr == MSR_REG_STATUS);
  assign link_up = link_ok;

  function automatic logic [15:0] status_compose(logic done, logic fault, logic lnk);
    logic [15:0] w;
    w = MSR_STATUS_FIXED;
    w[MSR_BIT_NEG_DONE] = done;
    w[MSR_BIT_REMOTE_FAULT] = fault;
    w[MSR_BIT_LINK_UP] = lnk;
    return w;
  endfunction : status_compose

  assign status_word = status_compose(neg_done_q, fault_q, link_latch_q);

  // Negotiation complete flag, registered
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      neg_done_q <= 1'b0;
    end else begin
      neg_done_q <= link_in.neg_done;
    end
  end

  // Remote fault: set wins over clear on read
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      fault_q <= 1'b0;
    end else if (link_in.remote_fault) begin
      fault_q <= 1'b1;
    end else if (rd_status) begin
      fault_q <= 1'b0;
    end
  end

  // Link status latches low; a read reloads present state
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      link_latch_q <= 1'b0;
    end else if (!link_ok) begin
      link_latch_q <= 1'b0;
    end else if (rd_status) begin
      link_latch_q <= 1'b1;
    end
  end

  // Read data; writes never alter state
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata_q <= MSR_ZERO16;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= mgmt_req.rd;
      if (mgmt_req.rd) begin
        unique case (mgmt_req.addr)
          MSR_REG_STATUS: rdata_q <= status_word;
          MSR_REG_ID_HI: rdata_q <= id_hi;
          MSR_REG_ID_LO: rdata_q <= id_lo;
          default: rdata_q <= MSR_ZERO16;
        endcase
      end
    end
  end

  assign mgmt_rdata = rdata_q;
  assign mgmt_rvalid = rvalid_q;

  chk_fixed_bits: assert property (@(posedge mclk) disable iff (!rstn)
    rd_status |=> (mgmt_rdata[15:9] == 7'h00 && mgmt_rdata[8:6] == 3'h7)) else $error("fixed high bits wrong");
  chk_low_fixed: assert property (@(posedge mclk) disable iff (!rstn)
    rd_status |=> (mgmt_rdata[3] && !mgmt_rdata[1] && !mgmt_rdata[0])) else $error("fixed low bits wrong");
  chk_ext_status: assert property (@(posedge mclk) disable iff (!rstn)
    rd_status |=> mgmt_rdata[MSR_BIT_EXT_STATUS]) else $error("extended status bit low");
  chk_unidir_bit: assert property (@(posedge mclk) disable iff (!rstn)
    rd_status |=> mgmt_rdata[MSR_BIT_UNIDIR] && mgmt_rdata[MSR_BIT_PREAMBLE_SUP]) else $error("bit 7 or 6 low");
  chk_neg_done: assert property (@(posedge mclk) disable iff (!rstn)
    rd_status && neg_done_q |=> mgmt_rdata[MSR_BIT_NEG_DONE]) else $error("negotiation done not shown");
  chk_fault_clear: assert property (@(posedge mclk) disable iff (!rstn)
    rd_status && !link_in.remote_fault |=> !fault_q) else $error("fault not cleared on read");
  chk_fault_set: assert property (@(posedge mclk) disable iff (!rstn)
    link_in.remote_fault |=> fault_q) else $error("fault event lost");
  chk_link_latch: assert property (@(posedge mclk) disable iff (!rstn)
    !link_ok ##1 link_ok [*2] |-> !link_latch_q || $past(rd_status)) else $error("link rose without read");
  chk_write_ignored: assert property (@(posedge mclk) disable iff (!rstn)
    mgmt_req.wr && !mgmt_req.rd && !link_in.remote_fault && link_ok |=> $stable(fault_q) && $stable(link_latch_q))
    else $error("write changed state");
  chk_id_read: assert property (@(posedge mclk) disable iff (!rstn)
    mgmt_req.rd && mgmt_req.addr == MSR_REG_ID_LO |=> mgmt_rdata == id_lo) else $error("id read wrong");
endmodule : msr_status_regs

// *** tb/msr_station.sv ***
// Management station model issuing register reads and writes
`timescale 1ns/1ps
module msr_station import msr_pkg::*; (
  // Clock
  input wire logic mclk,
  // Answer from the bank
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid,
  // Request to the bank
  output msr_mgmt_req_s mgmt_req
);
  initial mgmt_req = '0;
  // One access, strobe held for a single cycle, answer awaited for a bounded time
  task automatic access(input logic w, input logic [4:0] a, output logic [15:0] d, output logic ok);
    @(posedge mclk);
    mgmt_req.rd <= !w;
    mgmt_req.wr <= w;
    mgmt_req.addr <= a;
    mgmt_req.wdata <= 16'hFFFF;
    @(posedge mclk);
    mgmt_req <= '0;
    ok = w;
    d = 16'h0000;
    for (int i = 0; i < 3 && !ok; i++) begin
      #1;
      if (mgmt_rvalid === 1'b1) begin
        ok = 1'b1;
        d = mgmt_rdata;
      end else begin
        @(posedge mclk);
      end
    end
  endtask : access
  // Status read repeated once when link shows low
  task automatic reread(output logic [15:0] d, output logic ok);
    access(1'b0, MSR_REG_STATUS, d, ok);
    if (ok && !d[MSR_BIT_LINK_UP]) access(1'b0, MSR_REG_STATUS, d, ok);
  endtask : reread
endmodule : msr_station

// *** tb/testbench.sv ***
// Self-checking bench for the status and identifier register bank
`timescale 1ns/1ps
module testbench import msr_pkg::*; ;
  localparam int LT = 20;
  logic mclk, rstn, link_up, mgmt_rvalid, ok;
  logic [15:0] mgmt_rdata, d;
  msr_mgmt_req_s mgmt_req;
  msr_link_s link_in;
  int n_mismatch = 0;
  int tests_run = 0;
  int n;
  msr_status_regs #(.LINK_TIMER_CYC(LT)) uut (.mclk(mclk), .rstn(rstn), .mgmt_req(mgmt_req),
    .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .link_in(link_in), .link_up(link_up));
  msr_station stn (.mclk(mclk), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .mgmt_req(mgmt_req));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string what);
    stn.access(1'b0, a, d, ok);
    if (ok !== 1'b1) begin
      $display("[FAIL] %s answer expected 1 seen 0", what);
      n_mismatch++;
      end_sim();
    end
    chk(what, exp, d);
  endtask : rd
  task automatic wait_link(input logic v, input int lim);
    n = 0;
    while (link_up !== v && n < lim) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (link_up !== v) begin
      $display("[FAIL] link level expected %b seen %b", v, link_up);
      n_mismatch++;
      end_sim();
    end
  endtask : wait_link
  task automatic t_fixed();
    rd(MSR_REG_STATUS, 16'h01C8, "status after reset");
    rd(MSR_REG_ID_HI, 16'h0000, "id high");
    rd(MSR_REG_ID_LO, 16'h0411, "id low");
    rd(5'h05, 16'h0000, "unmapped");
    $display("t_fixed done");
  endtask : t_fixed
  task automatic t_link();
    @(posedge mclk);
    link_in <= 5'b11010;
    repeat (6) @(posedge mclk);
    #1;
    chk("link without negotiation", 16'h0000, {15'h0, link_up});
    link_in.neg_done <= 1'b1;
    wait_link(1'b1, 4);
    chk("link up", 16'h0001, {15'h0, link_up});
    rd(MSR_REG_STATUS, 16'h01E8, "latched link");
    stn.reread(d, ok);
    chk("present link", 16'h01EC, d);
    $display("t_link done");
  endtask : t_link
  task automatic t_write();
    stn.access(1'b1, MSR_REG_STATUS, d, ok);
    stn.access(1'b1, MSR_REG_ID_LO, d, ok);
    rd(MSR_REG_STATUS, 16'h01EC, "status after write");
    rd(MSR_REG_ID_LO, 16'h0411, "id after write");
    $display("t_write done");
  endtask : t_write
  task automatic t_fault();
    @(posedge mclk);
    link_in.remote_fault <= 1'b1;
    @(posedge mclk);
    link_in.remote_fault <= 1'b0;
    rd(MSR_REG_STATUS, 16'h01FC, "fault set");
    rd(MSR_REG_STATUS, 16'h01EC, "fault cleared");
    $display("t_fault done");
  endtask : t_fault
  task automatic t_timer();
    @(posedge mclk);
    link_in.sync_ok <= 1'b0;
    link_in.neg_enable <= 1'b0;
    link_in.neg_done <= 1'b0;
    wait_link(1'b0, LT + 8);
    chk("link hold", 16'h0001, {15'h0, n >= LT && n <= LT + 3});
    rd(MSR_REG_STATUS, 16'h01C8, "link lost");
    @(posedge mclk);
    link_in.sync_ok <= 1'b1;
    wait_link(1'b1, 4);
    rd(MSR_REG_STATUS, 16'h01C8, "loss still latched");
    rd(MSR_REG_STATUS, 16'h01CC, "link back");
    $display("t_timer done");
  endtask : t_timer
  initial begin
    rstn = 1'b0;
    link_in = '0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    t_fixed();
    t_link();
    t_write();
    t_fault();
    t_timer();
    end_sim();
  end
endmodule : testbench
